// ---- plldc_pkg.sv ----
/*
 * Constants and types shared by the PLL divider configuration slice:
 * register indexes, field positions, widths and reset values.
 * Assumes a 32-bit APB with word-aligned registers, byte address equal
 * to four times the register index.
 */
package plldc_pkg;

  // ********************************************************
  // Register indexes (byte address is four times the index)
  // ********************************************************
  localparam logic [9:0] REF_DIV_LOW_IDX = 10'h011;
  localparam logic [9:0] REF_DIV_HIGH_IDX = 10'h012;
  localparam logic [9:0] SWALLOW_COUNT_IDX = 10'h013;
  localparam logic [9:0] MAIN_FB_COUNT_LOW_IDX = 10'h014;
  localparam logic [9:0] MAIN_FB_COUNT_HIGH_IDX = 10'h015;
  localparam logic [9:0] PLL_COUNTER_CONTROL_IDX = 10'h016;

  // ********************************************************
  // Bus and field widths
  // ********************************************************
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;
  localparam int BYTE_W = 8;
  localparam int REF_DIV_W = 14;
  localparam int REF_HIGH_W = 6;
  localparam int SWALLOW_W = 6;
  localparam int MAIN_FB_W = 13;
  localparam int MAIN_HIGH_W = 5;

  // ********************************************************
  // Control register bit positions
  // ********************************************************
  localparam int CHARGE_PUMP_MID_BIT = 7;
  localparam int REF_HOLD_BIT = 6;
  localparam int FB_HOLD_BIT = 5;
  localparam int ALL_HOLD_BIT = 4;
  localparam logic [7:0] CONTROL_MASK = 8'hf0;

  // ********************************************************
  // Reset values
  // ********************************************************
  localparam logic [7:0] REF_DIV_LOW_RST = 8'h01;
  localparam logic [5:0] REF_DIV_HIGH_RST = 6'h00;
  localparam logic [5:0] SWALLOW_COUNT_RST = 6'h00;
  localparam logic [7:0] MAIN_FB_COUNT_LOW_RST = 8'h03;
  localparam logic [4:0] MAIN_FB_COUNT_HIGH_RST = 5'h00;
  localparam logic [7:0] CONTROL_RST = 8'h00;

  // Register selected by an address
  typedef enum logic [2:0] {
    SEL_NONE,
    SEL_REF_LOW,
    SEL_REF_HIGH,
    SEL_SWALLOW,
    SEL_MAIN_LOW,
    SEL_MAIN_HIGH,
    SEL_CONTROL
  } plldc_sel_type;

  // Decode a byte address; misaligned words hit nothing
  function automatic plldc_sel_type plldc_decode(
    input logic [ADDR_W-1:0] addr
  );
    plldc_sel_type sel;
    sel = SEL_NONE;
    if (addr[1:0] == 2'h0) begin
      unique case (addr[ADDR_W-1:2])
        REF_DIV_LOW_IDX: sel = SEL_REF_LOW;
        REF_DIV_HIGH_IDX: sel = SEL_REF_HIGH;
        SWALLOW_COUNT_IDX: sel = SEL_SWALLOW;
        MAIN_FB_COUNT_LOW_IDX: sel = SEL_MAIN_LOW;
        MAIN_FB_COUNT_HIGH_IDX: sel = SEL_MAIN_HIGH;
        PLL_COUNTER_CONTROL_IDX: sel = SEL_CONTROL;
        default: sel = SEL_NONE;
      endcase
    end
    return sel;
  endfunction : plldc_decode

endpackage : plldc_pkg

// ---- plldc_div_counter.sv ----
/*
 * Programmable divide counter used for the reference, swallow and main
 * feedback dividers. Emits a one-cycle tick every divide-value cycles.
 * Assumes the divide value and hold come from pclk-domain registers.
 */
`timescale 1ns/1ns

module plldc_div_counter #(
  parameter int WIDTH = 8
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Control
  input wire logic hold,
  input wire logic [WIDTH-1:0] divide_value,
  // Status
  output logic [WIDTH-1:0] count_q,
  output logic tick_q
);

  logic [WIDTH:0] count_inc;
  logic wrap;

  // A divide value of zero or one wraps every cycle
  assign count_inc = {1'b0, count_q} + {{WIDTH{1'b0}}, 1'b1};
  assign wrap = count_inc >= {1'b0, divide_value};

  // Count, held at zero while in reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_q <= '0;
    end else if (hold) begin
      count_q <= '0;
    end else if (wrap) begin
      count_q <= '0;
    end else begin
      count_q <= count_inc[WIDTH-1:0];
    end
  end

  // Terminal count pulse, silent while held
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_q <= 1'b0;
    end else begin
      tick_q <= !hold && wrap;
    end
  end

endmodule : plldc_div_counter

// ---- plldc_regs.sv ----
/*
 * PLL divider configuration registers behind an APB slave, with the
 * reference, swallow and main feedback divide counters they steer.
 * Assumes one clock (pclk) and a 32-bit APB master; no wait states.
 */
// Operation
// RL1: The 14-bit reference count keeps its low byte at 0x011, reset 0x01.
// RL2: Reference count bits 13:8 sit in field [5:0] at 0x012, reset 0x00.
// RL3: The 6-bit swallow count sits in field [5:0] at 0x013, reset 0x00.
// RL4: The 13-bit main feedback count has its low byte at 0x014, reset 0x03.
// RL5: Main count bits 12:8 sit in field [4:0] at 0x015, reset 0x00.
// RL6: Control bit 7 parks the charge-pump output at half its supply.
// RL7: Control bit 6 holds the reference counter in reset while set.
// RL8: Control bit 5 holds swallow and main feedback counters in reset.
// RL9: Control bit 4 holds all three counters in reset while set.
// RL10: Multi-byte counts are joined from their bytes; unused bits read 0.
`timescale 1ns/1ns

module plldc_regs (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [plldc_pkg::ADDR_W-1:0] paddr,
  input wire logic [plldc_pkg::DATA_W-1:0] pwdata,
  output logic [plldc_pkg::DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  // Assembled divide values
  output logic [plldc_pkg::REF_DIV_W-1:0] ref_div_count,
  output logic [plldc_pkg::SWALLOW_W-1:0] swallow_count_value,
  output logic [plldc_pkg::MAIN_FB_W-1:0] main_fb_count,
  // Charge pump and counter holds
  output logic charge_pump_output_mid,
  output logic ref_counter_hold,
  output logic fb_counters_hold,
  // Divider outputs
  output logic ref_div_tick,
  output logic swallow_tick,
  output logic main_fb_tick
);

  import plldc_pkg::*;

  // ********************************************************
  // Declarations
  // ********************************************************
  logic [7:0] ref_div_low_q;
  logic [5:0] ref_div_high_q;
  logic [5:0] swallow_count_q;
  logic [7:0] main_fb_count_low_q;
  logic [4:0] main_fb_count_high_q;
  logic [7:0] control_q;
  logic [DATA_W-1:0] prdata_q;
  logic [DATA_W-1:0] prdata_d;
  logic pslverr_q;
  logic setup_phase;
  logic wr_en;
  plldc_sel_type sel;
  logic [REF_DIV_W-1:0] ref_cnt;
  logic [SWALLOW_W-1:0] swallow_cnt;
  logic [MAIN_FB_W-1:0] main_cnt;

  // ********************************************************
  // APB decode
  // ********************************************************
  // Zero wait states: every access completes in its first access cycle
  assign pready = 1'b1;
  assign setup_phase = psel && !penable;
  assign wr_en = psel && penable && pwrite;
  assign sel = plldc_decode(paddr);

  // ********************************************************
  // Divider registers
  // ********************************************************
  // Reference divider bytes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ref_div_low_q <= REF_DIV_LOW_RST; // RL1
      ref_div_high_q <= REF_DIV_HIGH_RST; // RL2
    end else if (wr_en && sel == SEL_REF_LOW) begin
      ref_div_low_q <= pwdata[BYTE_W-1:0]; // RL1
    end else if (wr_en && sel == SEL_REF_HIGH) begin
      ref_div_high_q <= pwdata[REF_HIGH_W-1:0]; // RL2
    end
  end

  // Swallow count
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      swallow_count_q <= SWALLOW_COUNT_RST; // RL3
    end else if (wr_en && sel == SEL_SWALLOW) begin
      swallow_count_q <= pwdata[SWALLOW_W-1:0]; // RL3
    end
  end

  // Main feedback bytes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      main_fb_count_low_q <= MAIN_FB_COUNT_LOW_RST; // RL4
      main_fb_count_high_q <= MAIN_FB_COUNT_HIGH_RST; // RL5
    end else if (wr_en && sel == SEL_MAIN_LOW) begin
      main_fb_count_low_q <= pwdata[BYTE_W-1:0]; // RL4
    end else if (wr_en && sel == SEL_MAIN_HIGH) begin
      main_fb_count_high_q <= pwdata[MAIN_HIGH_W-1:0]; // RL5
    end
  end

  // Control; only the four defined bits are stored
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      control_q <= CONTROL_RST;
    end else if (wr_en && sel == SEL_CONTROL) begin
      control_q <= pwdata[BYTE_W-1:0] & CONTROL_MASK;
    end
  end

  // ********************************************************
  // Read path
  // ********************************************************
  // Read data are chosen in the setup cycle so they leave a flip-flop
  always_comb begin
    prdata_d = '0;
    unique case (sel)
      SEL_REF_LOW: prdata_d[BYTE_W-1:0] = ref_div_low_q;
      SEL_REF_HIGH: prdata_d[REF_HIGH_W-1:0] = ref_div_high_q; // RL10
      SEL_SWALLOW: prdata_d[SWALLOW_W-1:0] = swallow_count_q; // RL10
      SEL_MAIN_LOW: prdata_d[BYTE_W-1:0] = main_fb_count_low_q;
      SEL_MAIN_HIGH: prdata_d[MAIN_HIGH_W-1:0] = main_fb_count_high_q; // RL10
      SEL_CONTROL: prdata_d[BYTE_W-1:0] = control_q;
      SEL_NONE: prdata_d = '0;
    endcase
  end

  // Latch read data and the unmapped-address error at setup
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= '0;
      pslverr_q <= 1'b0;
    end else if (setup_phase) begin
      prdata_q <= pwrite ? '0 : prdata_d;
      pslverr_q <= sel == SEL_NONE;
    end
  end

  // Error shown only in the access phase, as APB requires
  assign prdata = prdata_q;
  assign pslverr = pslverr_q && psel && penable;

  // ********************************************************
  // Assembled values and control outputs
  // ********************************************************
  // Byte pairs joined into full divide values
  assign ref_div_count = {ref_div_high_q, ref_div_low_q}; // RL10
  assign swallow_count_value = swallow_count_q;
  assign main_fb_count = {main_fb_count_high_q, main_fb_count_low_q}; // RL10

  // Holds: the all-counters bit overrides either single hold
  assign charge_pump_output_mid = control_q[CHARGE_PUMP_MID_BIT]; // RL6
  assign ref_counter_hold = control_q[REF_HOLD_BIT] // RL7
    || control_q[ALL_HOLD_BIT]; // RL9
  assign fb_counters_hold = control_q[FB_HOLD_BIT] // RL8
    || control_q[ALL_HOLD_BIT]; // RL9

  // ********************************************************
  // Divide counters
  // ********************************************************
  // Reference divider
  plldc_div_counter #(
    .WIDTH(REF_DIV_W)
  ) u_ref_counter (
    .pclk(pclk),
    .presetn(presetn),
    .hold(ref_counter_hold),
    .divide_value(ref_div_count),
    .count_q(ref_cnt),
    .tick_q(ref_div_tick)
  );

  // Swallow counter, held together with the main counter
  plldc_div_counter #(
    .WIDTH(SWALLOW_W)
  ) u_swallow_counter (
    .pclk(pclk),
    .presetn(presetn),
    .hold(fb_counters_hold),
    .divide_value(swallow_count_value),
    .count_q(swallow_cnt),
    .tick_q(swallow_tick)
  );

  // Main feedback counter
  plldc_div_counter #(
    .WIDTH(MAIN_FB_W)
  ) u_main_counter (
    .pclk(pclk),
    .presetn(presetn),
    .hold(fb_counters_hold),
    .divide_value(main_fb_count),
    .count_q(main_cnt),
    .tick_q(main_fb_tick)
  );

  // ********************************************************
  // Assertions
  // ********************************************************
  // Low reference byte takes the written byte at the access edge
  property p_ref_low_write;
    @(posedge pclk) disable iff (!presetn)
    (wr_en && sel == SEL_REF_LOW) |=>
      ref_div_low_q == $past(pwdata[BYTE_W-1:0]);
  endproperty
  a_ref_low_write: assert property (p_ref_low_write) // RL1
    else $error("reference low byte not written");

  // High reference field keeps six bits and joins the count
  property p_ref_high_write;
    @(posedge pclk) disable iff (!presetn)
    (wr_en && sel == SEL_REF_HIGH) |=>
      ref_div_count[REF_DIV_W-1:BYTE_W] == $past(pwdata[REF_HIGH_W-1:0]);
  endproperty
  a_ref_high_write: assert property (p_ref_high_write) // RL2
    else $error("reference high field not written");

  // Swallow field stored from six bits
  property p_swallow_write;
    @(posedge pclk) disable iff (!presetn)
    (wr_en && sel == SEL_SWALLOW) |=>
      swallow_count_value == $past(pwdata[SWALLOW_W-1:0]);
  endproperty
  a_swallow_write: assert property (p_swallow_write) // RL3
    else $error("swallow count not written");

  // Main low byte joins the feedback count
  property p_main_low_write;
    @(posedge pclk) disable iff (!presetn)
    (wr_en && sel == SEL_MAIN_LOW) |=>
      main_fb_count[BYTE_W-1:0] == $past(pwdata[BYTE_W-1:0]);
  endproperty
  a_main_low_write: assert property (p_main_low_write) // RL4
    else $error("main feedback low byte not written");

  // Main high field keeps five bits
  property p_main_high_write;
    @(posedge pclk) disable iff (!presetn)
    (wr_en && sel == SEL_MAIN_HIGH) |=>
      main_fb_count[MAIN_FB_W-1:BYTE_W] == $past(pwdata[MAIN_HIGH_W-1:0]);
  endproperty
  a_main_high_write: assert property (p_main_high_write) // RL5
    else $error("main feedback high field not written");

  // Charge-pump park follows the written control bit
  property p_cp_mid;
    @(posedge pclk) disable iff (!presetn)
    (wr_en && sel == SEL_CONTROL) |=>
      charge_pump_output_mid == $past(pwdata[CHARGE_PUMP_MID_BIT]);
  endproperty
  a_cp_mid: assert property (p_cp_mid) // RL6
    else $error("charge pump park bit not applied");

  // Reference counter stays at zero and silent while held
  property p_ref_hold;
    @(posedge pclk) disable iff (!presetn)
    control_q[REF_HOLD_BIT] ##1 control_q[REF_HOLD_BIT] |->
      ref_cnt == '0 && !ref_div_tick;
  endproperty
  a_ref_hold: assert property (p_ref_hold) // RL7
    else $error("reference counter ran while held");

  // Feedback counters stay at zero and silent while held
  property p_fb_hold;
    @(posedge pclk) disable iff (!presetn)
    control_q[FB_HOLD_BIT] ##1 control_q[FB_HOLD_BIT] |->
      swallow_cnt == '0 && main_cnt == '0 && !main_fb_tick
      && !swallow_tick;
  endproperty
  a_fb_hold: assert property (p_fb_hold) // RL8
    else $error("feedback counters ran while held");

  // Global hold stops all three counters
  property p_all_hold;
    @(posedge pclk) disable iff (!presetn)
    control_q[ALL_HOLD_BIT] ##1 control_q[ALL_HOLD_BIT] |->
      ref_cnt == '0 && swallow_cnt == '0 && main_cnt == '0
      && !ref_div_tick && !swallow_tick && !main_fb_tick;
  endproperty
  a_all_hold: assert property (p_all_hold) // RL9
    else $error("counter ran under global hold");

  // Main feedback high field reads back with zero upper bits
  property p_read_upper_zero;
    @(posedge pclk) disable iff (!presetn)
    (setup_phase && !pwrite && sel == SEL_MAIN_HIGH) |=>
      prdata[DATA_W-1:MAIN_HIGH_W] == '0
      && prdata[MAIN_HIGH_W-1:0] == $past(main_fb_count_high_q);
  endproperty
  a_read_upper_zero: assert property (p_read_upper_zero) // RL10
    else $error("partial register read back wrong");

  // An unmapped access answers with an error in its access cycle
  property p_unmapped_err;
    @(posedge pclk) disable iff (!presetn)
    (setup_phase && sel == SEL_NONE) ##1 (psel && penable) |->
      pslverr;
  endproperty
  a_unmapped_err: assert property (p_unmapped_err)
    else $error("unmapped access without error");

  // Reference high field reads back with zero upper bits
  property p_read_ref_high;
    @(posedge pclk) disable iff (!presetn)
    (setup_phase && !pwrite && sel == SEL_REF_HIGH) |=>
      prdata == {{(DATA_W-REF_HIGH_W){1'b0}}, $past(ref_div_high_q)};
  endproperty
  a_read_ref_high: assert property (p_read_ref_high) // RL10
    else $error("reference high field read back wrong");

  // Swallow field reads back with zero upper bits
  property p_read_swallow;
    @(posedge pclk) disable iff (!presetn)
    (setup_phase && !pwrite && sel == SEL_SWALLOW) |=>
      prdata == {{(DATA_W-SWALLOW_W){1'b0}}, $past(swallow_count_q)};
  endproperty
  a_read_swallow: assert property (p_read_swallow) // RL10
    else $error("swallow field read back wrong");

  // Control reads back only its four defined bits
  property p_read_control;
    @(posedge pclk) disable iff (!presetn)
    (setup_phase && !pwrite && sel == SEL_CONTROL) |=>
      (prdata & ~{{(DATA_W-BYTE_W){1'b0}}, CONTROL_MASK}) == '0;
  endproperty
  a_read_control: assert property (p_read_control)
    else $error("control reserved bits read back set");

  // A refused write leaves every register as it was
  property p_refused_write;
    @(posedge pclk) disable iff (!presetn)
    (wr_en && sel == SEL_NONE) |=>
      $stable(ref_div_count) && $stable(main_fb_count)
      && $stable(swallow_count_q) && $stable(control_q);
  endproperty
  a_refused_write: assert property (p_refused_write)
    else $error("refused write changed a register");

endmodule : plldc_regs

// ---- test_plldc_regs.sv ----
/*
 * Self-checking testbench for the PLL divider configuration slice.
 * Assumes plldc_pkg is compiled first; APB slave answers with no waits,
 * but the bench master waits for pready; only the watchdog ends a wait.
 */
`timescale 1ns/1ns

module test_plldc_regs;
  import plldc_pkg::*;

  // ****************************************************************
  // Signals and instance
  // ****************************************************************
  logic pclk;
  logic presetn;
  logic psel;
  logic penable;
  logic pwrite;
  logic [ADDR_W-1:0] paddr;
  logic [DATA_W-1:0] pwdata;
  logic [DATA_W-1:0] prdata;
  logic pready;
  logic pslverr;
  logic [REF_DIV_W-1:0] ref_div_count;
  logic [SWALLOW_W-1:0] swallow_count_value;
  logic [MAIN_FB_W-1:0] main_fb_count;
  logic charge_pump_output_mid;
  logic ref_counter_hold;
  logic fb_counters_hold;
  logic ref_div_tick;
  logic swallow_tick;
  logic main_fb_tick;
  int fail_count = 0;
  int n_tests = 0;
  int ref_ticks = 0;
  int sw_ticks = 0;
  int main_ticks = 0;

  plldc_regs dut_u (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .ref_div_count(ref_div_count),
    .swallow_count_value(swallow_count_value),
    .main_fb_count(main_fb_count),
    .charge_pump_output_mid(charge_pump_output_mid),
    .ref_counter_hold(ref_counter_hold),
    .fb_counters_hold(fb_counters_hold), .ref_div_tick(ref_div_tick),
    .swallow_tick(swallow_tick), .main_fb_tick(main_fb_tick)
  );

  // Byte addresses are the register index times four
  localparam logic [ADDR_W-1:0] A_RL = {REF_DIV_LOW_IDX, 2'h0};
  localparam logic [ADDR_W-1:0] A_RH = {REF_DIV_HIGH_IDX, 2'h0};
  localparam logic [ADDR_W-1:0] A_SW = {SWALLOW_COUNT_IDX, 2'h0};
  localparam logic [ADDR_W-1:0] A_ML = {MAIN_FB_COUNT_LOW_IDX, 2'h0};
  localparam logic [ADDR_W-1:0] A_MH = {MAIN_FB_COUNT_HIGH_IDX, 2'h0};
  localparam logic [ADDR_W-1:0] A_CT = {PLL_COUNTER_CONTROL_IDX, 2'h0};

  // ****************************************************************
  // Clock, tick counters and watchdog
  // ****************************************************************
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  // Ticks are counted as the design's flops present them
  always @(posedge pclk) begin
    if (ref_div_tick === 1'b1) ref_ticks <= ref_ticks + 1;
    if (swallow_tick === 1'b1) sw_ticks <= sw_ticks + 1;
    if (main_fb_tick === 1'b1) main_ticks <= main_ticks + 1;
  end

  // The whole run needs well under a thousand cycles
  initial begin
    repeat (5000) @(posedge pclk);
    fail_count++;
    close_out();
  end

  // ****************************************************************
  // Tasks
  // ****************************************************************
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask : check

  // One APB transfer; held until pready is seen high at an edge
  task automatic apb(input logic w, input logic [ADDR_W-1:0] a,
                     input logic [31:0] d, output logic [31:0] rd,
                     output logic err);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
    logic [31:0] rd;
    logic err;
    apb(1'b1, a, d, rd, err);
  endtask : wr

  // Reads and compares data and the error response together
  task automatic rd_chk(input logic [ADDR_W-1:0] a, input logic [31:0] e,
                        input logic e_err);
    logic [31:0] rd;
    logic err;
    apb(1'b0, a, 32'h0, rd, err);
    check(rd, e);
    check({31'h0, err}, {31'h0, e_err});
  endtask : rd_chk

  // Counts ticks over 24 cycles, a multiple of every divide used
  task automatic tick_chk(input int er, input int es, input int em);
    int r0;
    int s0;
    int m0;
    repeat (8) @(posedge pclk);
    #1;
    r0 = ref_ticks;
    s0 = sw_ticks;
    m0 = main_ticks;
    repeat (24) @(posedge pclk);
    #1;
    check(32'(ref_ticks - r0), 32'(er));
    check(32'(sw_ticks - s0), 32'(es));
    check(32'(main_ticks - m0), 32'(em));
  endtask : tick_chk

  task automatic close_out;
    $display("comparisons %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : close_out

  // ****************************************************************
  // Test sequence
  // ****************************************************************
  initial begin
    logic [3:0] bit_n;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    presetn = 1'b0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;

    // Reset values on registers and assembled outputs
    rd_chk(A_RL, 32'h01, 1'b0);
    rd_chk(A_RH, 32'h00, 1'b0);
    rd_chk(A_SW, 32'h00, 1'b0);
    rd_chk(A_ML, 32'h03, 1'b0);
    rd_chk(A_MH, 32'h00, 1'b0);
    rd_chk(A_CT, 32'h00, 1'b0);
    check(32'(ref_div_count), 32'h0001);
    check(32'(main_fb_count), 32'h0003);
    $display("test reset values done");

    // Writes with all upper bits set: unused upper bits must read back as zero
    wr(A_RL, 32'hffff_ffa5);
    wr(A_RH, 32'hffff_ffff);
    wr(A_SW, 32'hffff_ffff);
    wr(A_ML, 32'hffff_ff5a);
    wr(A_MH, 32'hffff_ffff);
    rd_chk(A_RL, 32'ha5, 1'b0);
    rd_chk(A_RH, 32'h3f, 1'b0);
    rd_chk(A_SW, 32'h3f, 1'b0);
    rd_chk(A_ML, 32'h5a, 1'b0);
    rd_chk(A_MH, 32'h1f, 1'b0);
    check(32'(ref_div_count), 32'h3fa5);
    check(32'(swallow_count_value), 32'h3f);
    check(32'(main_fb_count), 32'h1f5a);
    $display("test field widths done");

    // Unmapped and misaligned accesses are refused and change nothing
    rd_chk(12'h040, 32'h0, 1'b1);
    rd_chk(12'h05c, 32'h0, 1'b1);
    wr(12'h045, 32'h0000_0011);
    wr(12'h05c, 32'h0000_00ff);
    rd_chk(A_RL, 32'ha5, 1'b0);
    rd_chk(A_CT, 32'h00, 1'b0);
    $display("test refused accesses done");

    // Small divides so tick counts over 24 cycles are exact
    wr(A_RL, 32'h03);
    wr(A_RH, 32'h00);
    wr(A_SW, 32'h02);
    wr(A_ML, 32'h04);
    wr(A_MH, 32'h00);
    tick_chk(8, 12, 6);

    // Each control bit alone; low nibble is not stored
    for (int i = 0; i < 4; i++) begin
      bit_n = 4'(7 - i);
      wr(A_CT, (32'h1 << bit_n) | 32'h0f);
      rd_chk(A_CT, 32'h1 << bit_n, 1'b0);
      @(posedge pclk);
      #1;
      check({31'h0, charge_pump_output_mid}, 32'(bit_n == 7));
      check({31'h0, ref_counter_hold}, 32'(bit_n == 6 || bit_n == 4));
      check({31'h0, fb_counters_hold}, 32'(bit_n == 5 || bit_n == 4));
      tick_chk((bit_n == 6 || bit_n == 4) ? 0 : 8,
               (bit_n == 5 || bit_n == 4) ? 0 : 12,
               (bit_n == 5 || bit_n == 4) ? 0 : 6);
    end
    wr(A_CT, 32'h00);
    tick_chk(8, 12, 6);
    $display("test control bits done");
    close_out();
  end

endmodule : test_plldc_regs
